// >>> verilog/ccl_pkg.sv
// constants for the comparator control logic: register map, fields, codes
// assumes a 32-bit AXI4-Lite master and byte addresses of four times the index
//
// Contract
// - mux enabled and converter off: channel select routes shared pin 0..7 to negative input
// - mux disabled or converter on: dedicated negative pin feeds the negative input
// - disable bit one powers the comparator off, zero powers it on
// - bandgap bit one feeds the reference to positive input, zero the positive pin
// - result bit shows comparator output through a one-to-two cycle synchroniser
// - hardware sets the interrupt flag on the event chosen by the mode bits
// - flag clears on vector execution or written one; written zero keeps it
// - request raised only while flag, enable and global enable are all one
// - capture enable one drives capture front end; zero leaves no connection
// - mode zero toggle, one reserved, two falling edge, three rising edge
// - buffer-off bit turns off pin input buffer; its port bit reads zero
// - result is one when positive input exceeds negative input, else zero
package ccl_pkg;
   // register indices; byte address is index times four
   localparam logic [9:0] CSR_IDX  = 10'h050;
   localparam logic [9:0] CSRB_IDX = 10'h07B;
   localparam logic [9:0] AUX_IDX  = 10'h07E;
   localparam logic [9:0] DIDR_IDX = 10'h07F;
   // comparator_control_status fields
   localparam int CSR_DIS  = 7;
   localparam int CSR_BG   = 6;
   localparam int CSR_RES  = 5;
   localparam int CSR_FLAG = 4;
   localparam int CSR_IEN  = 3;
   localparam int CSR_CAP  = 2;
   localparam int CSR_MODE = 0;
   // converter_control_status_b fields
   localparam int CSRB_MUXEN = 6;
   // converter_link fields
   localparam int AUX_CONV = 7;
   localparam int AUX_GIE  = 6;
   localparam int AUX_CHAN = 0;
   // digital_input_disable_one fields
   localparam int DIDR_NEG = 1;
   localparam int DIDR_POS = 0;
   // writable bits and reset values
   localparam logic [7:0] CSR_WMASK  = 8'hCF;
   localparam logic [7:0] CSRB_WMASK = 8'h47;
   localparam logic [7:0] AUX_WMASK  = 8'hC7;
   localparam logic [7:0] DIDR_WMASK = 8'h03;
   localparam logic [7:0] REG_RESET  = 8'h00;
   // interrupt modes
   localparam logic [1:0] MODE_TOGGLE = 2'h0;
   localparam logic [1:0] MODE_RSVD   = 2'h1;
   localparam logic [1:0] MODE_FALL   = 2'h2;
   localparam logic [1:0] MODE_RISE   = 2'h3;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> verilog/ccl_top.sv
// comparator control logic: input select, result sync, edge flag, capture route
// assumes analog comparator and pins outside, AXI4-Lite master on MCLK
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module ccl_top
   import ccl_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              MCLK,
   input  wire logic              RST,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   input  wire logic [31:0]       WDATA,
   input  wire logic [3:0]        WSTRB,
   input  wire logic              WVALID,
   output logic                   WREADY,
   output logic [1:0]             BRESP,
   output logic                   BVALID,
   input  wire logic              BREADY,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   output logic [31:0]            RDATA,
   output logic [1:0]             RRESP,
   output logic                   RVALID,
   input  wire logic              RREADY,
   // analog comparator and pins
   input  wire logic              CMP_RAW,
   input  wire logic              PIN_NEG_RAW,
   input  wire logic              PIN_POS_RAW,
   output logic                   CMP_POWER_OFF,
   output logic                   POS_BANDGAP,
   output logic                   NEG_FROM_MUX,
   output logic [2:0]             NEG_CHANNEL,
   output logic                   NEG_BUF_OFF,
   output logic                   POS_BUF_OFF,
   output logic                   PIN_NEG_READ,
   output logic                   PIN_POS_READ,
   // capture and interrupt
   output logic                   CAPTURE_INPUT,
   input  wire logic              IRQ_VECTOR_ACK,
   output logic                   CMP_IRQ
);

   // register index sits in address bits 11:2
   if (ADDR_W < 12) begin : g_addr_check
      $error("ADDR_W too small for register map");
   end

   ////////////////////////////////////////////////////////////////////////
   // bus handshake state
   logic              aw_have_r;
   logic              w_have_r;
   logic [9:0]        aw_idx_r;
   logic [7:0]        w_data_r;
   logic              w_lane_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              arready_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;

   // registers
   logic [7:0]        csr_r;
   logic [7:0]        csrb_r;
   logic [7:0]        aux_r;
   logic [7:0]        didr_r;
   logic              flag_r;

   // sync and outputs
   logic              cmp_s1_r;
   logic              cmp_s2_r;
   logic              cmp_prev_r;
   logic              pn_s1_r;
   logic              pn_s2_r;
   logic              pp_s1_r;
   logic              pp_s2_r;
   logic              neg_mux_r;
   logic              cap_r;
   logic              irq_r;
   logic              pin_neg_r;
   logic              pin_pos_r;

   ////////////////////////////////////////////////////////////////////////
   // write path decode
   wire        aw_take    = AWVALID & awready_r;
   wire        w_take     = WVALID & wready_r;
   wire        do_write   = aw_have_r & w_have_r & ~bvalid_r;
   wire        aw_hit_csr = aw_idx_r == CSR_IDX;
   wire        aw_hit_b   = aw_idx_r == CSRB_IDX;
   wire        aw_hit_aux = aw_idx_r == AUX_IDX;
   wire        aw_hit_di  = aw_idx_r == DIDR_IDX;
   wire        aw_mapped  = aw_hit_csr | aw_hit_b | aw_hit_aux | aw_hit_di;
   wire        wr_lo      = do_write & w_lane_r;
   wire        wr_csr     = wr_lo & aw_hit_csr;
   wire        wr_b       = wr_lo & aw_hit_b;
   wire        wr_aux     = wr_lo & aw_hit_aux;
   wire        wr_di      = wr_lo & aw_hit_di;
   wire        aw_have_nxt = (aw_have_r | aw_take) & ~do_write;
   wire        w_have_nxt  = (w_have_r | w_take) & ~do_write;
   wire        bvalid_nxt  = do_write | (bvalid_r & ~BREADY);
   wire        awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
   wire        wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
   wire [7:0]  csr_nxt  = (csr_r & ~CSR_WMASK) | (w_data_r & CSR_WMASK);
   wire [7:0]  csrb_nxt = w_data_r & CSRB_WMASK;
   wire [7:0]  aux_nxt  = w_data_r & AUX_WMASK;
   wire [7:0]  didr_nxt = w_data_r & DIDR_WMASK;

   // read path decode
   wire        ar_take    = ARVALID & arready_r;
   wire [9:0]  ar_idx     = ARADDR[11:2];
   wire        ar_hit_csr = ar_idx == CSR_IDX;
   wire        ar_hit_b   = ar_idx == CSRB_IDX;
   wire        ar_hit_aux = ar_idx == AUX_IDX;
   wire        ar_hit_di  = ar_idx == DIDR_IDX;
   wire        ar_mapped  = ar_hit_csr | ar_hit_b | ar_hit_aux | ar_hit_di;
   wire        rvalid_nxt = ar_take | (rvalid_r & ~RREADY);
   wire [7:0]  csr_view   = {csr_r[7:6], cmp_s2_r, flag_r, csr_r[3:0]};
   wire [7:0]  rd_byte    = ar_hit_csr ? csr_view :
                            ar_hit_b   ? csrb_r   :
                            ar_hit_aux ? aux_r    :
                            ar_hit_di  ? didr_r   : REG_RESET;

   ////////////////////////////////////////////////////////////////////////
   // comparator control fields
   wire        muxen    = csrb_r[CSRB_MUXEN];
   wire        conv_en  = aux_r[AUX_CONV];
   wire        gie      = aux_r[AUX_GIE];
   wire [1:0]  mode     = csr_r[CSR_MODE +: 2];
   wire        ien      = csr_r[CSR_IEN];
   wire        cap_en   = csr_r[CSR_CAP];
   wire        use_mux  = muxen & ~conv_en;

   // edge decode on synchronised result
   wire        ev_rise  = cmp_s2_r & ~cmp_prev_r;
   wire        ev_fall  = ~cmp_s2_r & cmp_prev_r;
   wire        ev_any   = cmp_s2_r ^ cmp_prev_r;
   wire        event_hit = (mode == MODE_TOGGLE) ? ev_any  :
                           (mode == MODE_FALL)   ? ev_fall :
                           (mode == MODE_RISE)   ? ev_rise : 1'b0;
   wire        flag_clr = IRQ_VECTOR_ACK | (wr_csr & w_data_r[CSR_FLAG]);
   wire        flag_nxt = event_hit | (flag_r & ~flag_clr);

   ////////////////////////////////////////////////////////////////////////
   // write channel
   always_ff @(posedge MCLK) begin
      if (RST) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
      end else begin
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         aw_idx_r <= 10'h000;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else begin
         if (aw_take) aw_idx_r <= AWADDR[11:2];
         if (w_take) w_data_r <= WDATA[7:0];
         if (w_take) w_lane_r <= WSTRB[0];
         if (do_write) bresp_r <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // read channel
   always_ff @(posedge MCLK) begin
      if (RST) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OKAY;
      end else begin
         arready_r <= ~rvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         if (ar_take) rdata_r <= {24'h00_0000, rd_byte};
         if (ar_take) rresp_r <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge MCLK) begin
      if (RST) begin
         csr_r  <= REG_RESET;
         csrb_r <= REG_RESET;
         aux_r  <= REG_RESET;
         didr_r <= REG_RESET;
         flag_r <= 1'b0;
      end else begin
         if (wr_csr) csr_r <= csr_nxt;
         if (wr_b) csrb_r <= csrb_nxt;
         if (wr_aux) aux_r <= aux_nxt;
         if (wr_di) didr_r <= didr_nxt;
         flag_r <= flag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // synchronisers; raw high means positive input above negative
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cmp_s1_r   <= 1'b0;
         cmp_s2_r   <= 1'b0;
         cmp_prev_r <= 1'b0;
         pn_s1_r    <= 1'b0;
         pn_s2_r    <= 1'b0;
         pp_s1_r    <= 1'b0;
         pp_s2_r    <= 1'b0;
      end else begin
         cmp_s1_r   <= CMP_RAW;
         cmp_s2_r   <= cmp_s1_r;
         cmp_prev_r <= cmp_s2_r;
         pn_s1_r    <= PIN_NEG_RAW;
         pn_s2_r    <= pn_s1_r;
         pp_s1_r    <= PIN_POS_RAW;
         pp_s2_r    <= pp_s1_r;
      end
   end

   // registered outputs
   always_ff @(posedge MCLK) begin
      if (RST) begin
         neg_mux_r <= 1'b0;
         cap_r     <= 1'b0;
         irq_r     <= 1'b0;
         pin_neg_r <= 1'b0;
         pin_pos_r <= 1'b0;
      end else begin
         neg_mux_r <= use_mux;
         cap_r     <= cap_en & cmp_s2_r;
         irq_r     <= flag_r & ien & gie;
         pin_neg_r <= pn_s2_r & ~didr_r[DIDR_NEG];
         pin_pos_r <= pp_s2_r & ~didr_r[DIDR_POS];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port drive
   assign AWREADY       = awready_r;
   assign WREADY        = wready_r;
   assign BVALID        = bvalid_r;
   assign BRESP         = bresp_r;
   assign ARREADY       = arready_r;
   assign RVALID        = rvalid_r;
   assign RDATA         = rdata_r;
   assign RRESP         = rresp_r;
   assign CMP_POWER_OFF = csr_r[CSR_DIS];
   assign POS_BANDGAP   = csr_r[CSR_BG];
   assign NEG_FROM_MUX  = neg_mux_r;
   assign NEG_CHANNEL   = aux_r[AUX_CHAN +: 3];
   assign NEG_BUF_OFF   = didr_r[DIDR_NEG];
   assign POS_BUF_OFF   = didr_r[DIDR_POS];
   assign PIN_NEG_READ  = pin_neg_r;
   assign PIN_POS_READ  = pin_pos_r;
   assign CAPTURE_INPUT = cap_r;
   assign CMP_IRQ       = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   a_neg_mux_route: assert property (use_mux |=> NEG_FROM_MUX)
      else $error("mux route not applied");
   a_neg_pin_default: assert property (!use_mux |=> !NEG_FROM_MUX)
      else $error("dedicated negative pin not applied");
   a_power_off_write: assert property (wr_csr |=>
      CMP_POWER_OFF == $past(w_data_r[CSR_DIS]))
      else $error("disable bit write not applied");
   a_bandgap_select: assert property (wr_csr |=>
      POS_BANDGAP == $past(w_data_r[CSR_BG]))
      else $error("bandgap select not applied");
   a_result_sync: assert property (!$past(RST, 2) |->
      cmp_s2_r == $past(CMP_RAW, 2))
      else $error("result sync delay wrong");
   a_flag_rise_set: assert property ((mode == MODE_RISE && ev_rise)
      |=> flag_r)
      else $error("flag not set on rising edge");
   a_flag_fall_set: assert property ((mode == MODE_FALL) && ev_fall
      |=> flag_r)
      else $error("flag not set on falling edge");
   a_flag_ack_clear: assert property (flag_r && IRQ_VECTOR_ACK
      && !event_hit |=> !flag_r)
      else $error("flag not cleared by vector");
   a_flag_zero_keeps: assert property (flag_r && !IRQ_VECTOR_ACK
      && !(wr_csr && w_data_r[CSR_FLAG]) |=> flag_r)
      else $error("flag lost without clear");
   a_irq_gate: assert property (CMP_IRQ |-> $past(flag_r && ien && gie))
      else $error("request without flag and enables");
   a_capture_route: assert property (!cap_en |=> !CAPTURE_INPUT)
      else $error("capture driven while disconnected");
   a_mode_reserved: assert property (mode == MODE_RSVD && !flag_r
      && $stable(mode) |=> !flag_r)
      else $error("flag set in reserved mode");
   a_buffer_off_read: assert property (didr_r[DIDR_NEG] |=> !PIN_NEG_READ)
      else $error("disabled pin reads nonzero");
   a_write_answer: assert property (aw_take && w_take |=> ##1 BVALID)
      else $error("write answer late");

   c_rise_flag: cover property (mode == MODE_RISE ##1 ev_rise ##1 flag_r);
   c_irq_raised: cover property (CMP_IRQ);
   c_capture_high: cover property (CAPTURE_INPUT);
   c_mux_route: cover property (NEG_FROM_MUX ##1 wr_aux);
endmodule

// >>> verification/ccl_comparator_model.sv
// analog comparator and input selection model facing the control logic
// assumes millivolt levels driven by the bench, select lines from ccl_top
`timescale 1ns/100ps
module ccl_comparator_model (
   // select controls
   input  wire logic        power_off,
   input  wire logic        bandgap,
   input  wire logic        from_mux,
   input  wire logic [2:0]  channel,
   // levels in millivolts
   input  wire logic [15:0] pos_mv,
   input  wire logic [15:0] neg_mv,
   input  wire logic [15:0] bg_mv,
   input  wire logic [15:0] ch_mv [8],
   // comparator output
   output logic             result
);
   logic [15:0] pos_v;
   logic [15:0] neg_v;
   assign pos_v  = bandgap ? bg_mv : pos_mv;
   assign neg_v  = from_mux ? ch_mv[channel] : neg_mv;
   assign result = !power_off && (pos_v > neg_v);
endmodule

// >>> verification/ccl_tb.sv
// self-checking bench for the comparator control logic
// assumes ccl_top, ccl_pkg and the comparator model alongside
`timescale 1ns/100ps
module comparator_control_logic_tb_top;
   import ccl_pkg::*;
   localparam logic [11:0] A_CSR  = {CSR_IDX, 2'b00};
   localparam logic [11:0] A_CSRB = {CSRB_IDX, 2'b00};
   localparam logic [11:0] A_AUX  = {AUX_IDX, 2'b00};
   localparam logic [11:0] A_DIDR = {DIDR_IDX, 2'b00};
   localparam logic [11:0] A_BAD  = 12'h0004;
   logic        mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, cmp_raw, pin_neg_raw, pin_pos_raw;
   logic        power_off, bandgap, from_mux, neg_buf_off, pos_buf_off;
   logic        neg_read, pos_read, capture, irq_ack, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [2:0]  channel;
   logic [15:0] pos_mv, neg_mv, bg_mv;
   logic [15:0] ch_mv [8];
   int          err_count, checks;
   logic [3:0]  strb_sel;

   ccl_top uut (.MCLK(mclk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .CMP_RAW(cmp_raw), .PIN_NEG_RAW(pin_neg_raw), .PIN_POS_RAW(pin_pos_raw),
      .CMP_POWER_OFF(power_off), .POS_BANDGAP(bandgap), .NEG_FROM_MUX(from_mux),
      .NEG_CHANNEL(channel), .NEG_BUF_OFF(neg_buf_off), .POS_BUF_OFF(pos_buf_off),
      .PIN_NEG_READ(neg_read), .PIN_POS_READ(pos_read), .CAPTURE_INPUT(capture),
      .IRQ_VECTOR_ACK(irq_ack), .CMP_IRQ(irq));
   ccl_comparator_model cmp (.power_off(power_off), .bandgap(bandgap), .from_mux(from_mux),
      .channel(channel), .pos_mv(pos_mv), .neg_mv(neg_mv), .bg_mv(bg_mv), .ch_mv(ch_mv),
      .result(cmp_raw));

   always #12.5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      aw = 1;
      w = 1;
      @(posedge mclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= strb_sel;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      forever begin
         @(posedge mclk);
         if (bvalid) break;
         if (aw && awready) begin
            aw = 0;
            awvalid <= 0;
         end
         if (w && wready) begin
            w = 0;
            wvalid <= 0;
         end
      end
      r = bresp;
      bready <= 0;
   endtask
   task automatic wo(input logic [11:0] a, input logic [7:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk("bresp", r, RESP_OKAY);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      forever begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(nm, d & {24'h00_0000, m}, {24'h00_0000, e});
      chk("rresp", r, RESP_OKAY);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rchk("csr", A_CSR, 8'hFF, REG_RESET);
      rchk("csrb", A_CSRB, 8'hFF, REG_RESET);
      rchk("aux", A_AUX, 8'hFF, REG_RESET);
      rchk("didr", A_DIDR, 8'hFF, REG_RESET);
      rd(A_BAD, d, r);
      chk("bad_rresp", r, RESP_SLVERR);
      chk("bad_rdata", d, 0);
      wr(A_BAD, 8'hFF, r);
      chk("bad_bresp", r, RESP_SLVERR);
   endtask
   task automatic t_route;
      wo(A_CSRB, 8'h40);
      for (int k = 0; k < 8; k++) begin
         wo(A_AUX, 8'(k));
         cyc(4);
         chk("from_mux", from_mux, 1);
         chk("channel", channel, k);
         rchk("mux_res", A_CSR, 8'h20, (k < 4) ? 8'h20 : 8'h00);
      end
      wo(A_AUX, 8'h87);
      cyc(4);
      chk("conv_on", from_mux, 0);
      rchk("pin_res", A_CSR, 8'h20, 8'h20);
      wo(A_AUX, 8'h07);
      wo(A_CSRB, 8'h00);
      cyc(4);
      chk("mux_off", from_mux, 0);
      rchk("pin_res2", A_CSR, 8'h20, 8'h20);
   endtask
   task automatic t_power;
      // reserved mode keeps the flag quiet while power and reference move
      wo(A_CSR, 8'h11);
      wo(A_CSR, 8'hC1);
      chk("power_off", power_off, 1);
      chk("bandgap", bandgap, 1);
      cyc(4);
      rchk("off_res", A_CSR, 8'hFF, 8'hC1);
      wo(A_CSR, 8'h41);
      chk("power_on", power_off, 0);
      cyc(4);
      rchk("bg_res", A_CSR, 8'hFF, 8'h41);
      wo(A_CSR, 8'h01);
      chk("bg_off", bandgap, 0);
      cyc(4);
      rchk("pos_res", A_CSR, 8'hFF, 8'h21);
   endtask
   task automatic t_capture;
      wo(A_CSR, 8'h04);
      pos_mv <= 16'd0;
      cyc(5);
      chk("cap_low", capture, 0);
      @(posedge mclk);
      pos_mv <= 16'd400;
      cyc(1);
      chk("cap_early", capture, 0);
      cyc(2);
      chk("cap_high", capture, 1);
      wo(A_CSR, 8'h10);
      cyc(2);
      chk("cap_off", capture, 0);
   endtask
   task automatic t_modes;
      logic [3:0] er;
      logic [3:0] ef;
      er = 4'b1001;
      ef = 4'b0101;
      pos_mv <= 16'd0;
      cyc(6);
      for (int m = 0; m < 4; m++) begin
         wo(A_CSR, 8'h10 | 8'(m));
         pos_mv <= 16'd400;
         cyc(6);
         rchk("flag_rise", A_CSR, 8'h10, er[m] ? 8'h10 : 8'h00);
         wo(A_CSR, 8'h10 | 8'(m));
         pos_mv <= 16'd0;
         cyc(6);
         rchk("flag_fall", A_CSR, 8'h10, ef[m] ? 8'h10 : 8'h00);
      end
   endtask
   task automatic t_irq;
      wo(A_CSR, 8'h10);
      pos_mv <= 16'd400;
      cyc(6);
      wo(A_CSR, 8'h08);
      rchk("flag_keep", A_CSR, 8'h10, 8'h10);
      cyc(2);
      chk("irq_nogie", irq, 0);
      wo(A_AUX, 8'h40);
      cyc(2);
      chk("irq_on", irq, 1);
      wo(A_CSR, 8'h00);
      cyc(2);
      chk("irq_masked", irq, 0);
      wo(A_CSR, 8'h08);
      cyc(2);
      chk("irq_again", irq, 1);
      @(posedge mclk);
      irq_ack <= 1;
      @(posedge mclk);
      irq_ack <= 0;
      cyc(2);
      chk("irq_acked", irq, 0);
      rchk("flag_ack", A_CSR, 8'h10, 8'h00);
      pos_mv <= 16'd0;
      cyc(6);
      chk("irq_fall", irq, 1);
      wo(A_CSR, 8'h18);
      cyc(2);
      rchk("flag_w1c", A_CSR, 8'h10, 8'h00);
      chk("irq_clr", irq, 0);
      wo(A_CSR, 8'h00);
   endtask
   task automatic t_pins;
      pin_neg_raw <= 1;
      pin_pos_raw <= 1;
      cyc(5);
      chk("neg_read", neg_read, 1);
      chk("pos_read", pos_read, 1);
      wo(A_DIDR, 8'h01);
      cyc(3);
      chk("pos_off", pos_buf_off, 1);
      chk("pos_zero", pos_read, 0);
      chk("neg_kept", neg_read, 1);
      wo(A_DIDR, 8'h02);
      cyc(5);
      chk("neg_off", neg_buf_off, 1);
      chk("neg_zero", neg_read, 0);
      chk("pos_back", pos_read, 1);
      rchk("didr", A_DIDR, 8'hFF, 8'h02);
      // byte lane 0 not strobed: register must keep its value
      strb_sel = 4'h0;
      wo(A_DIDR, 8'h03);
      strb_sel = 4'hF;
      rchk("didr_nolane", A_DIDR, 8'hFF, 8'h02);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      summarize();
   end
   initial begin
      {mclk, awvalid, wvalid, bready, arvalid, rready, pin_neg_raw, pin_pos_raw, irq_ack} = 0;
      {awaddr, araddr, wdata, wstrb} = 0;
      strb_sel = 4'hF;
      rst = 1;
      pos_mv = 16'd0;
      neg_mv = 16'd300;
      bg_mv = 16'd200;
      for (int k = 0; k < 8; k++) ch_mv[k] = 16'(100 * k);
      pos_mv = 16'd350;
      repeat (6) @(posedge mclk);
      rst <= 0;
      pos_mv <= 16'd0;
      cyc(4);
      t_reset();
      pos_mv <= 16'd350;
      t_route();
      pos_mv <= 16'd400;
      t_power();
      t_capture();
      t_modes();
      t_irq();
      t_pins();
      summarize();
   end
endmodule
